// ===== sdr_pkg.sv
package sdr_pkg;
  // Frame field positions
  localparam int FRAME_W = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int SEL_BIT = 13;
  localparam int RO_BIT = 12;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  // Status image layout
  localparam int ST_CAUSE_HI = 11;
  localparam int ST_CAUSE_LO = 8;
  localparam int ST_LEVEL_WAKE = 6;
  localparam int ST_EDGE_WAKE = 4;
  localparam int ST_THERMAL = 3;
  localparam int ST_DEV_MODE = 2;
  localparam int ST_ENABLE = 1;
  localparam int ST_POWER_ON = 0;
  // Diagnosis image layout
  localparam int DG_GROUND = 11;
  localparam int DG_CAN_HI = 10;
  localparam int DG_CAN_LO = 7;
  localparam int DG_LIN_HI = 6;
  localparam int DG_LIN_LO = 5;
  localparam int DG_SUPPLY3 = 4;
  localparam int DG_SUPPLY2 = 3;
  localparam int DG_MAIN = 2;
  localparam int DG_CANMODE_HI = 1;
  localparam int DG_CANMODE_LO = 0;
  localparam logic [3:0] CAN_RESERVED = 4'ha;
  localparam logic [3:0] CAUSE_POWER_ON = 4'h0;
  // Development-mode fail-safe undervoltage time
  localparam int DEV_UV_MS = 256;
  localparam int CLOCK_HZ = 20000000;
  localparam int DEV_UV_CYCLES = DEV_UV_MS * (CLOCK_HZ / 1000);
  // CAN transceiver modes
  localparam logic [1:0] CAN_OFFLINE = 2'h0;
  localparam logic [1:0] CAN_SEL_SLEEP = 2'h1;
  localparam logic [1:0] CAN_ONLINE = 2'h2;
endpackage

// ===== sdr_sync.sv
module sdr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Asynchronous in, filtered out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Three-stage capture
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Change accepted when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          sync_out[i] <= 1'b0;
        end else if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule // sdr_sync

// ===== sdr_status_system_diagnosis_regs.sv
// Operation
// - Falling edge on wake pin sets status bit 4; status read clears it.
// - Status bit 3 mirrors the temperature-above-warning condition.
// - Bit 2 shows development mode; it suppresses monitors, fail-safe only after 256 ms.
// - Status bit 1 mirrors the enable output pin being driven high.
// - Bit 0 set by power-on reset, cleared after normal or flash mode entry.
// - Reset cause overwritten on every reset event, never cleared.
// - Address 00 with select 1 returns the diagnosis image.
// - Read-only bit 1 just reads; 0 on an address 00 frame also writes payload to mode register.
// - Diagnosis bit 11 shows ground shift beyond threshold.
// - Diagnosis bits 10..7 carry the CAN fault code.
// - Diagnosis bits 6..5 carry the LIN fault code.
// - Bit 4 clears on supply3 short, sets again on software reactivation.
// - Bit 3 reads 0 after supply2 short shutdown, 1 while healthy.
// - Supply2 restarts on CAN mode set, control bit fall, off-line exit.
// - Bit 2 latches 0 on main supply dip, returns to 1 after read.
// - Address 00 with select 0 returns the status image.
module sdr_status_system_diagnosis_regs #(
  parameter int DEV_UV_CYCLES = sdr_pkg::DEV_UV_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Serial frame from host, decoded to words
  input wire logic frame_start,
  input wire logic frame_done,
  input wire logic [15:0] frame_word,
  // Pins from outside the clock domain
  input wire logic wake_pin,
  input wire logic enable_pin,
  // Same-domain condition inputs
  input wire logic thermal_warning,
  input wire logic dev_mode_set,
  input wire logic dev_mode_clear,
  input wire logic normal_or_flash_entered,
  input wire logic reset_event,
  input wire logic [3:0] reset_cause,
  input wire logic ground_shift,
  input wire logic [3:0] can_fault_code,
  input wire logic [1:0] lin_fault_code,
  input wire logic supply3_short,
  input wire logic supply3_control_on,
  input wire logic supply2_short,
  input wire logic can_mode_set,
  input wire logic can_transmitter_control,
  input wire logic [1:0] can_mode,
  input wire logic main_supply_low,
  input wire logic main_supply_uv,
  // Read data and mode write
  output logic [15:0] read_data,
  output logic mode_write,
  output logic [11:0] mode_payload,
  // Device control
  output logic supply2_enable,
  output logic monitors_suppressed,
  output logic failsafe_request
);
  logic [1:0] pins_sync;
  logic wake_prev;
  logic edge_wake_flag;
  logic thermal_warning_flag;
  logic dev_mode_flag;
  logic enable_flag;
  logic power_on_flag;
  logic [3:0] cause;
  logic ground_shift_flag;
  logic supply3_ok;
  logic supply2_ok;
  logic main_supply_ok;
  logic ctc_prev;
  logic [1:0] can_mode_prev;
  logic in_frame;
  logic frame_system_diagnosis;
  logic [31:0] uv_count;
  logic status_read_done;
  logic system_diagnosis_read_done;
  logic wake_fall;
  logic supply2_restart;
  logic wake_since_start;
  logic low_since_start;

  sdr_sync #(.WIDTH(2)) sdr_sync_i (
    .clock(clock),
    .reset(reset),
    .async_in({enable_pin, wake_pin}),
    .sync_out(pins_sync)
  );

  function automatic logic is_system_diagnosis(input logic [15:0] w);
    is_system_diagnosis = (w[sdr_pkg::ADDR_HI:sdr_pkg::ADDR_LO] == sdr_pkg::ADDR_STATUS)
      && w[sdr_pkg::SEL_BIT];
  endfunction

  function automatic logic is_status(input logic [15:0] w);
    is_status = (w[sdr_pkg::ADDR_HI:sdr_pkg::ADDR_LO] == sdr_pkg::ADDR_STATUS)
      && !w[sdr_pkg::SEL_BIT];
  endfunction

  assign wake_fall = wake_prev && !pins_sync[0];
  assign status_read_done = frame_done && in_frame && !frame_system_diagnosis;
  assign system_diagnosis_read_done = frame_done && in_frame && frame_system_diagnosis;
  assign supply2_restart = can_mode_set
    || (ctc_prev && !can_transmitter_control)
    || ((can_mode_prev == sdr_pkg::CAN_OFFLINE)
      && ((can_mode == sdr_pkg::CAN_ONLINE) || (can_mode == sdr_pkg::CAN_SEL_SLEEP)));

  // Edge history
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_prev <= 1'b0;
      ctc_prev <= 1'b0;
      can_mode_prev <= sdr_pkg::CAN_OFFLINE;
    end else begin
      wake_prev <= pins_sync[0];
      ctc_prev <= can_transmitter_control;
      can_mode_prev <= can_mode;
    end
  end

  // Events after image capture
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_since_start <= 1'b0;
      low_since_start <= 1'b0;
    end else if (frame_start) begin
      wake_since_start <= wake_fall;
      low_since_start <= main_supply_low;
    end else begin
      wake_since_start <= wake_since_start || wake_fall;
      low_since_start <= low_since_start || main_supply_low;
    end
  end

  // Edge wake flag, set wins over clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      edge_wake_flag <= 1'b0;
    end else if (wake_fall) begin
      edge_wake_flag <= 1'b1;
    end else if (status_read_done && !wake_since_start) begin
      edge_wake_flag <= 1'b0;
    end
  end

  // Temperature warning level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      thermal_warning_flag <= 1'b0;
    end else begin
      thermal_warning_flag <= thermal_warning;
    end
  end

  // Enable pin level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      enable_flag <= 1'b0;
    end else begin
      enable_flag <= pins_sync[1];
    end
  end

  // Ground shift level
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ground_shift_flag <= 1'b0;
    end else begin
      ground_shift_flag <= ground_shift;
    end
  end

  // Development mode and its fail-safe timer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dev_mode_flag <= 1'b0;
    end else if (dev_mode_set) begin
      dev_mode_flag <= 1'b1;
    end else if (dev_mode_clear) begin
      dev_mode_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      uv_count <= '0;
      failsafe_request <= 1'b0;
    end else begin
      if (!main_supply_uv) begin
        uv_count <= '0;
      end else if (uv_count < 32'(DEV_UV_CYCLES)) begin
        uv_count <= uv_count + 32'h1;
      end
      failsafe_request <= dev_mode_flag && (uv_count >= 32'(DEV_UV_CYCLES));
    end
  end

  // Monitor suppression
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      monitors_suppressed <= 1'b0;
    end else begin
      monitors_suppressed <= dev_mode_flag;
    end
  end

  // Power-on flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      power_on_flag <= 1'b1;
    end else if (normal_or_flash_entered) begin
      power_on_flag <= 1'b0;
    end
  end

  // Last reset cause
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cause <= sdr_pkg::CAUSE_POWER_ON;
    end else if (reset_event) begin
      cause <= reset_cause;
    end
  end

  // Third supply diagnosis
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      supply3_ok <= 1'b1;
    end else if (supply3_short) begin
      supply3_ok <= 1'b0;
    end else if (supply3_control_on) begin
      supply3_ok <= 1'b1;
    end
  end

  // Second supply diagnosis and enable
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      supply2_ok <= 1'b1;
      supply2_enable <= 1'b1;
    end else if (supply2_short) begin
      supply2_ok <= 1'b0;
      supply2_enable <= 1'b0;
    end else if (supply2_restart) begin
      supply2_ok <= 1'b1;
      supply2_enable <= 1'b1;
    end
  end

  // Main supply diagnosis, dip wins over read
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      main_supply_ok <= 1'b1;
    end else if (main_supply_low) begin
      main_supply_ok <= 1'b0;
    end else if (system_diagnosis_read_done && !low_since_start) begin
      main_supply_ok <= 1'b1;
    end
  end

  // Frame capture and read image
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      in_frame <= 1'b0;
      frame_system_diagnosis <= 1'b0;
      read_data <= '0;
    end else if (frame_start) begin
      in_frame <= is_system_diagnosis(frame_word) || is_status(frame_word);
      frame_system_diagnosis <= is_system_diagnosis(frame_word);
      read_data <= '0;
      if (is_system_diagnosis(frame_word)) begin
        read_data[sdr_pkg::ADDR_HI:sdr_pkg::RO_BIT] <= frame_word[sdr_pkg::ADDR_HI:sdr_pkg::RO_BIT];
        read_data[sdr_pkg::DG_GROUND] <= ground_shift_flag;
        read_data[sdr_pkg::DG_CAN_HI:sdr_pkg::DG_CAN_LO] <= can_fault_code;
        read_data[sdr_pkg::DG_LIN_HI:sdr_pkg::DG_LIN_LO] <= lin_fault_code;
        read_data[sdr_pkg::DG_SUPPLY3] <= supply3_ok;
        read_data[sdr_pkg::DG_SUPPLY2] <= supply2_ok;
        read_data[sdr_pkg::DG_MAIN] <= main_supply_ok;
        read_data[sdr_pkg::DG_CANMODE_HI:sdr_pkg::DG_CANMODE_LO] <= can_mode;
      end else if (is_status(frame_word)) begin
        read_data[sdr_pkg::ADDR_HI:sdr_pkg::RO_BIT] <= frame_word[sdr_pkg::ADDR_HI:sdr_pkg::RO_BIT];
        read_data[sdr_pkg::ST_CAUSE_HI:sdr_pkg::ST_CAUSE_LO] <= cause;
        read_data[sdr_pkg::ST_LEVEL_WAKE] <= pins_sync[0];
        read_data[sdr_pkg::ST_EDGE_WAKE] <= edge_wake_flag;
        read_data[sdr_pkg::ST_THERMAL] <= thermal_warning_flag;
        read_data[sdr_pkg::ST_DEV_MODE] <= dev_mode_flag;
        read_data[sdr_pkg::ST_ENABLE] <= enable_flag;
        read_data[sdr_pkg::ST_POWER_ON] <= power_on_flag;
      end
    end else if (frame_done) begin
      in_frame <= 1'b0;
    end
  end

  // Mode register write at frame end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_write <= 1'b0;
      mode_payload <= '0;
    end else begin
      mode_write <= 1'b0;
      if (frame_done && in_frame && !frame_word[sdr_pkg::RO_BIT]) begin
        mode_write <= 1'b1;
        mode_payload <= frame_word[sdr_pkg::RO_BIT-1:0];
      end
    end
  end
endmodule // sdr_status_system_diagnosis_regs

// ===== sdr_status_system_diagnosis_regs_properties.sv
module sdr_checker (
  // Watched ports
  input wire logic clock,
  input wire logic reset,
  input wire logic frame_start,
  input wire logic frame_done,
  input wire logic [15:0] frame_word,
  input wire logic thermal_warning,
  input wire logic ground_shift,
  input wire logic [3:0] can_fault_code,
  input wire logic [1:0] lin_fault_code,
  input wire logic [15:0] read_data,
  input wire logic mode_write,
  input wire logic [11:0] mode_payload
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic st = frame_start && frame_word[15:13] == 3'h0;
  wire logic dg = frame_start && frame_word[15:13] == 3'h1;
  AST_THERMAL: assert property (st |=> read_data[3] == $past(thermal_warning, 2))
    else $error("thermal bit wrong");
  AST_SYSTEM_DIAGNOSIS_SEL: assert property (dg |=> read_data[15:13] == 3'h1)
    else $error("diagnosis image not chosen");
  AST_GROUND: assert property (dg |=> read_data[11] == $past(ground_shift, 2))
    else $error("ground bit wrong");
  AST_CAN: assert property (dg |=> read_data[10:7] == $past(can_fault_code))
    else $error("can code wrong");
  AST_LIN: assert property (dg |=> read_data[6:5] == $past(lin_fault_code))
    else $error("lin code wrong");
  AST_RSVD: assert property (st |=> !read_data[13] && !read_data[7] && !read_data[5])
    else $error("reserved bit set");
  AST_OTHER: assert property (frame_start && frame_word[15:14] != 2'h0 |=> read_data == 16'h0)
    else $error("other address gave data");
  AST_WRITE: assert property (frame_done && frame_word[15:14] == 2'h0 && !frame_word[12]
    |=> mode_write && mode_payload == $past(frame_word[11:0]))
    else $error("mode write missing");
  AST_RO: assert property (frame_done && frame_word[12] |=> !mode_write)
    else $error("read-only frame wrote");
endmodule // sdr_checker

bind sdr_status_system_diagnosis_regs sdr_checker sdr_checker_i (.clock, .reset, .frame_start, .frame_done,
  .frame_word, .thermal_warning, .ground_shift, .can_fault_code, .lin_fault_code, .read_data,
  .mode_write, .mode_payload);

// ===== sdr_host.sv
module sdr_host (
  // Link to block
  input wire logic clock,
  input wire logic [15:0] read_data,
  input wire logic mode_write,
  output logic frame_start,
  output logic frame_done,
  output logic [15:0] frame_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    frame_start = 1'b0;
    frame_done = 1'b0;
    frame_word = 16'h0;
  end
  // One frame, word held from start to done
  task automatic xfer(input logic [15:0] w, output logic [15:0] r, output logic mw);
    @(posedge clock);
    #1;
    frame_start = 1'b1;
    frame_word = w;
    @(posedge clock);
    #1;
    frame_start = 1'b0;
    r = read_data;
    @(posedge clock);
    #1;
    frame_done = 1'b1;
    @(posedge clock);
    #1;
    frame_done = 1'b0;
    mw = mode_write;
    frame_word = ~w;
    @(posedge clock);
    #1;
  endtask
endmodule // sdr_host

// ===== sdr_status_system_diagnosis_regs_tb.sv
module sdr_status_system_diagnosis_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset, wake_pin, enable_pin, thermal_warning, dev_mode_set, dev_mode_clear;
  logic normal_or_flash_entered, reset_event, ground_shift, supply3_short, supply3_control_on;
  logic supply2_short, can_mode_set, can_transmitter_control, main_supply_low, main_supply_uv;
  logic [3:0] reset_cause, can_fault_code;
  logic [1:0] lin_fault_code, can_mode;
  logic frame_start, frame_done, mode_write, supply2_enable, monitors_suppressed;
  logic failsafe_request, mw;
  logic [15:0] frame_word, read_data, r;
  logic [11:0] mode_payload;
  int n_fail, n_tests;
  sdr_status_system_diagnosis_regs #(.DEV_UV_CYCLES(20)) sdr_status_system_diagnosis_regs_i (.clock, .reset,
    .frame_start, .frame_done, .frame_word, .wake_pin, .enable_pin, .thermal_warning,
    .dev_mode_set, .dev_mode_clear, .normal_or_flash_entered, .reset_event, .reset_cause,
    .ground_shift, .can_fault_code, .lin_fault_code, .supply3_short, .supply3_control_on,
    .supply2_short, .can_mode_set, .can_transmitter_control, .can_mode, .main_supply_low,
    .main_supply_uv, .read_data, .mode_write, .mode_payload, .supply2_enable,
    .monitors_suppressed, .failsafe_request);
  sdr_host sdr_host_i (.clock, .read_data, .mode_write, .frame_start, .frame_done, .frame_word);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [15:0] w);
    sdr_host_i.xfer(w, r, mw);
  endtask
  task automatic t_levels;
    rd(16'h1000);
    chk(16'({r[11:8], r[4], r[0]}), 16'h1);
    enable_pin = 1'b1;
    thermal_warning = 1'b1;
    dev_mode_set = 1'b1;
    step(1);
    dev_mode_set = 1'b0;
    main_supply_uv = 1'b1;
    step(10);
    chk(16'({monitors_suppressed, failsafe_request}), 16'h2);
    step(20);
    chk(16'(failsafe_request), 16'h1);
    rd(16'h1000);
    chk(16'(r[3:1]), 16'h7);
    main_supply_uv = 1'b0;
    {enable_pin, thermal_warning, dev_mode_clear} = 3'h1;
    step(1);
    dev_mode_clear = 1'b0;
    step(4);
    rd(16'h1000);
    chk(16'(r[3:1]), 16'h0);
  endtask
  task automatic t_wake;
    wake_pin = 1'b0;
    step(6);
    wake_pin = 1'b1;
    step(6);
    rd(16'h1000);
    chk(16'(r[4]), 16'h1);
    fork
      rd(16'h1000);
      begin
        step(1);
        wake_pin = 1'b0;
      end
    join
    chk(16'(r[4]), 16'h0);
    wake_pin = 1'b1;
    rd(16'h1000);
    chk(16'(r[4]), 16'h1);
    wake_pin = 1'b0;
    step(2);
    rd(16'h1000);
    chk(16'(r[4]), 16'h0);
    rd(16'h1000);
    chk(16'(r[4]), 16'h1);
    wake_pin = 1'b1;
  endtask
  logic [3:0] n_cause [2] = '{4'hb, 4'h3};
  task automatic t_cause;
    foreach (n_cause[i]) begin
      reset_cause = n_cause[i];
      reset_event = 1'b1;
      step(1);
      reset_event = 1'b0;
      rd(16'h1000);
      rd(16'h1000);
      chk(16'(r[11:8]), 16'(n_cause[i]));
    end
    normal_or_flash_entered = 1'b1;
    step(1);
    normal_or_flash_entered = 1'b0;
    rd(16'h1000);
    chk(16'(r[0]), 16'h0);
  endtask
  task automatic t_system_diagnosis;
    for (int i = 0; i < 16; i++) begin
      can_fault_code = 4'(i);
      lin_fault_code = 2'(i);
      ground_shift = i[0];
      step(1);
      rd(16'h3000);
      chk(r & 16'hffe0, {4'h3, i[0], 4'(i), 2'(i), 5'h0});
    end
    rd(16'h2abc);
    chk(16'({mw, mode_payload}), 16'h1abc);
    rd(16'h3000);
    chk(16'(mw), 16'h0);
    rd(16'h0123);
    chk(16'({mw, mode_payload}), 16'h1123);
    rd(16'h4123);
    chk(16'(mw), 16'h0);
    rd(16'h5000);
    chk(r, 16'h0);
  endtask
  task automatic t_supply;
    supply3_short = 1'b1;
    step(1);
    supply3_short = 1'b0;
    rd(16'h3000);
    chk(16'(r[4:2]), 16'h3);
    supply3_control_on = 1'b1;
    rd(16'h3000);
    chk(16'(r[4]), 16'h1);
    can_transmitter_control = 1'b1;
    for (int k = 0; k < 3; k++) begin
      supply2_short = 1'b1;
      step(1);
      supply2_short = 1'b0;
      rd(16'h3000);
      chk(16'({supply2_enable, r[3]}), 16'h0);
      can_mode_set = k == 0;
      can_transmitter_control = k != 1;
      can_mode = k == 2 ? sdr_pkg::CAN_ONLINE : sdr_pkg::CAN_OFFLINE;
      step(1);
      can_mode_set = 1'b0;
      rd(16'h3000);
      chk(16'({supply2_enable, r[3]}), 16'h3);
      can_mode = sdr_pkg::CAN_OFFLINE;
    end
    main_supply_low = 1'b1;
    step(1);
    main_supply_low = 1'b0;
    rd(16'h3000);
    chk(16'(r[2]), 16'h0);
    rd(16'h3000);
    chk(16'(r[2]), 16'h1);
    fork
      rd(16'h3000);
      begin
        step(2);
        main_supply_low = 1'b1;
        step(1);
        main_supply_low = 1'b0;
      end
    join
    chk(16'(r[2]), 16'h1);
    rd(16'h3000);
    chk(16'(r[2]), 16'h0);
  endtask
  task automatic test_done;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    {enable_pin, thermal_warning, dev_mode_set, dev_mode_clear, normal_or_flash_entered} = '0;
    {reset_event, ground_shift, supply3_short, supply3_control_on, supply2_short} = '0;
    {can_mode_set, can_transmitter_control, main_supply_low, main_supply_uv} = '0;
    {reset_cause, can_fault_code, lin_fault_code, can_mode} = '0;
    wake_pin = 1'b1;
    reset = 1'b1;
    repeat (16) @(posedge clock);
    #1;
    reset = 1'b0;
    step(4);
    t_levels;
    t_wake;
    t_cause;
    t_system_diagnosis;
    t_supply;
    test_done;
  end
endmodule // sdr_status_system_diagnosis_regs_tb
